// ==== logic/msr_regs.vh ====
// Notes on behaviour
// - command recognised by opcode 1Ah, six bytes
// - block-descriptor disable bit ignored entirely
// - pc 0: current, else saved, else defaults
// - pc 1: changeable mask, real code/length
// - pc 2: defaults, unsupported parameters zero
// - pc 3: saved values, defaults if none
// - six page selectors; 3Fh sends all ascending
// - zero allocation length transfers no bytes
// - stop at smaller of reply, allocation
// - four-byte header, byte 0 length minus three
// - page code 1Dh, bit 6 zero
// - parameters-savable bit set to one
// - page length byte says eighteen follow
// - field order fixed, transport count one except under pc 1
`ifndef MSR_REGS_VH
`define MSR_REGS_VH

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
`define MSR_OPCODE 8'h1A
`define MSR_SEL_ALL 6'h3F
`define MSR_PC_CUR 2'h0
`define MSR_PC_CHG 2'h1
`define MSR_PC_DFLT 2'h2
`define MSR_PC_SAVED 2'h3

// ----------------------------------------------------------------
// page codes and full page lengths (code and length bytes included)
// ----------------------------------------------------------------
`define MSR_PG_EAA 8'h1D
`define MSR_PG_TGEO 8'h1E
`define MSR_PG_DCAP 8'h1F
`define MSR_PG_LCD 8'h22
`define MSR_PG_CFG 8'h3D
`define MSR_PG_EXT 8'h3E
`define MSR_LEN_EAA 9'h014
`define MSR_LEN_TGEO 9'h004
`define MSR_LEN_DCAP 9'h014
`define MSR_LEN_LCD 9'h054
`define MSR_LEN_CFG 9'h010
`define MSR_LEN_EXT 9'h022
`define MSR_HDR_LEN 9'h004
`define MSR_LEN_ALL (`MSR_LEN_EAA + `MSR_LEN_TGEO + `MSR_LEN_DCAP + `MSR_LEN_LCD + `MSR_LEN_CFG + `MSR_LEN_EXT)

// ----------------------------------------------------------------
// element address assignment page layout
// ----------------------------------------------------------------
`define MSR_EAA_BYTE0 8'h9D
`define MSR_EAA_PLEN 8'h12
`define MSR_EAA_FIRST 7'h02
`define MSR_EAA_LAST 7'h11
`define MSR_EAA_XCNT_HI 4'h2
`define MSR_EAA_XCNT_LO 4'h3

// ----------------------------------------------------------------
// default field values, high byte first per field
// ----------------------------------------------------------------
`define MSR_DF_XADDR 16'h0000
`define MSR_DF_XCNT 16'h0001
`define MSR_DF_SADDR 16'h0100
`define MSR_DF_SCNT 16'h0010
`define MSR_DF_IADDR 16'h0200
`define MSR_DF_ICNT 16'h0001
`define MSR_DF_DADDR 16'h0300
`define MSR_DF_DCNT 16'h0002
// changeable masks: start addresses may be altered, counts may not
`define MSR_CHG_ADDR 16'hFFFF
`define MSR_CHG_CNT 16'h0000

`endif

// ==== logic/msr_fifo.v ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// reply byte fifo with registered head stage
// ----------------------------------------------------------------
module msr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output reg out_valid_q,
  output reg [WIDTH-1:0] out_data_q,
  input wire out_ready,
  output wire idle
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  // head register keeps the output straight off a flop
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign push = in_valid && in_ready;
  assign pop = (cnt_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);
  assign idle = (cnt_q == {(AW+1){1'b0}}) && !out_valid_q;

  // storage array needs no reset, only pointers, count and head stage do
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  // pointers, count and head stage
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
        out_valid_q <= 1'b0;
      if (push && !pop)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // msr_fifo

// ==== logic/msr_page_mem.v ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// two banks of 16 page body bytes: 0 current, 1 saved
// ----------------------------------------------------------------
module msr_page_mem (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [4:0] rd_addr,
  output reg [7:0] rd_data_q
);
  reg [7:0] mem [0:31];

  // write port
  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // registered read, one cycle after the address
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= mem[rd_addr];
  end
endmodule // msr_page_mem

// ==== logic/msr_responder.v ====
`timescale 1ns/100ps
`include "msr_regs.vh"
// ----------------------------------------------------------------
// mode sense reply builder
// ----------------------------------------------------------------
module msr_responder (
  input wire clk,
  input wire arst_n,
  input wire cdb_valid,
  input wire [7:0] cdb_b0,
  input wire [7:0] cdb_b2,
  input wire [7:0] cdb_b4,
  input wire bus_reset,
  input wire pg_wr_en,
  input wire pg_wr_bank,
  input wire [3:0] pg_wr_addr,
  input wire [7:0] pg_wr_data,
  input wire [7:0] ext_byte,
  output reg [7:0] ext_page_q,
  output reg [6:0] ext_idx_q,
  output reg [1:0] ext_pc_q,
  output reg busy_q,
  output reg cmd_done_q,
  output reg cmd_reject_q,
  output wire [7:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  localparam ST_IDLE = 2'b00;
  localparam ST_FETCH = 2'b01;
  localparam ST_PUSH = 2'b10;
  localparam ST_DRAIN = 2'b11;

  // ----------------------------------------------------------------
  // page tables
  // ----------------------------------------------------------------
  // selector to page slot; 6 means all pages, 7 unsupported
  function [2:0] sel_slot;
    input [5:0] sel;
    begin
      case ({2'b00, sel})
        `MSR_PG_EAA: sel_slot = 3'd0;
        `MSR_PG_TGEO: sel_slot = 3'd1;
        `MSR_PG_DCAP: sel_slot = 3'd2;
        `MSR_PG_LCD: sel_slot = 3'd3;
        `MSR_PG_CFG: sel_slot = 3'd4;
        `MSR_PG_EXT: sel_slot = 3'd5;
        {2'b00, `MSR_SEL_ALL}: sel_slot = 3'd6;
        default: sel_slot = 3'd7;
      endcase
    end
  endfunction

  // slots are numbered in ascending page code order
  function [7:0] slot_code;
    input [2:0] slot;
    begin
      case (slot)
        3'd0: slot_code = `MSR_PG_EAA;
        3'd1: slot_code = `MSR_PG_TGEO;
        3'd2: slot_code = `MSR_PG_DCAP;
        3'd3: slot_code = `MSR_PG_LCD;
        3'd4: slot_code = `MSR_PG_CFG;
        default: slot_code = `MSR_PG_EXT;
      endcase
    end
  endfunction

  function [8:0] slot_len;
    input [2:0] slot;
    begin
      case (slot)
        3'd0: slot_len = `MSR_LEN_EAA;
        3'd1: slot_len = `MSR_LEN_TGEO;
        3'd2: slot_len = `MSR_LEN_DCAP;
        3'd3: slot_len = `MSR_LEN_LCD;
        3'd4: slot_len = `MSR_LEN_CFG;
        3'd5: slot_len = `MSR_LEN_EXT;
        default: slot_len = `MSR_LEN_ALL;
      endcase
    end
  endfunction

  // default body byte k, high byte of each field first
  function [7:0] eaa_dflt;
    input [3:0] k;
    reg [15:0] f;
    begin
      case (k[3:1])
        3'd0: f = `MSR_DF_XADDR;
        3'd1: f = `MSR_DF_XCNT;
        3'd2: f = `MSR_DF_SADDR;
        3'd3: f = `MSR_DF_SCNT;
        3'd4: f = `MSR_DF_IADDR;
        3'd5: f = `MSR_DF_ICNT;
        3'd6: f = `MSR_DF_DADDR;
        default: f = `MSR_DF_DCNT;
      endcase
      eaa_dflt = k[0] ? f[7:0] : f[15:8];
    end
  endfunction

  // odd fields are counts, even fields are addresses
  function [7:0] eaa_mask;
    input [3:0] k;
    reg [15:0] f;
    begin
      f = k[1] ? `MSR_CHG_CNT : `MSR_CHG_ADDR;
      eaa_mask = k[0] ? f[7:0] : f[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [1:0] st_q;
  reg [2:0] slot_q;
  reg [2:0] slot_last_q;
  reg [6:0] pos_q;
  reg hdr_q;
  reg [1:0] pc_q;
  reg [8:0] total_q;
  reg [8:0] limit_q;
  reg [8:0] sent_q;
  reg cur_valid_q;
  reg saved_valid_q;
  reg [7:0] byte_d;
  wire [2:0] sel;
  wire [8:0] reply_len;
  wire [6:0] k7;
  wire use_dflt;
  wire bank;
  wire [7:0] mem_rd;
  wire fifo_ready;
  wire fifo_idle;
  wire push;
  wire [8:0] sent_d;

  // cdb byte 1 (block descriptor disable) is not taken at all
  assign sel = sel_slot(cdb_b2[5:0]);
  assign reply_len = `MSR_HDR_LEN + slot_len(sel);
  assign k7 = pos_q - `MSR_EAA_FIRST;
  // defaults stand in where no current or saved copy exists
  assign use_dflt = (pc_q == `MSR_PC_DFLT)
    || (pc_q == `MSR_PC_CUR && !cur_valid_q && !saved_valid_q)
    || (pc_q == `MSR_PC_SAVED && !saved_valid_q);
  assign bank = !(pc_q == `MSR_PC_CUR && cur_valid_q);
  assign push = (st_q == ST_PUSH) && fifo_ready;
  assign sent_d = sent_q + 9'h001;

  msr_page_mem u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(pg_wr_en),
    .wr_addr({pg_wr_bank, pg_wr_addr}),
    .wr_data(pg_wr_data),
    .rd_addr({bank, k7[3:0]}),
    .rd_data_q(mem_rd)
  );

  msr_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_data(byte_d),
    .in_ready(fifo_ready),
    .out_valid_q(out_valid),
    .out_data_q(out_data),
    .out_ready(out_ready),
    .idle(fifo_idle)
  );

  // ----------------------------------------------------------------
  // reply byte for the current position
  // ----------------------------------------------------------------
  always @*
  begin
    byte_d = 8'h00;
    if (hdr_q)
    begin
      if (pos_q == 7'h00)
        byte_d = total_q[7:0] - 8'h03;
    end
    else if (slot_q == 3'd0)
    begin
      if (pos_q == 7'h00)
        byte_d = `MSR_EAA_BYTE0;
      else if (pos_q == 7'h01)
        byte_d = `MSR_EAA_PLEN;
      else if (pos_q >= `MSR_EAA_FIRST && pos_q <= `MSR_EAA_LAST)
      begin
        // body bytes in fixed field order; 18 and 19 stay zero
        if (pc_q == `MSR_PC_CHG)
          byte_d = eaa_mask(k7[3:0]);
        else if (k7[3:0] == `MSR_EAA_XCNT_HI)
          byte_d = 8'h00;
        else if (k7[3:0] == `MSR_EAA_XCNT_LO)
          byte_d = 8'h01;
        else if (use_dflt)
          byte_d = eaa_dflt(k7[3:0]);
        else
          byte_d = mem_rd;
      end
    end
    else
      byte_d = ext_byte;
  end

  // ----------------------------------------------------------------
  // value-validity flags
  // ----------------------------------------------------------------
  // a write sets its flag and wins over a bus reset in the same cycle
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cur_valid_q <= 1'b0;
      saved_valid_q <= 1'b0;
    end
    else
    begin
      if (pg_wr_en && !pg_wr_bank)
        cur_valid_q <= 1'b1;
      else if (bus_reset)
        cur_valid_q <= 1'b0;
      if (pg_wr_en && pg_wr_bank)
        saved_valid_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // one byte every two cycles at best; the fifo hides the gaps
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= ST_IDLE;
      slot_q <= 3'd0;
      slot_last_q <= 3'd0;
      pos_q <= 7'h00;
      hdr_q <= 1'b0;
      pc_q <= 2'h0;
      total_q <= 9'h000;
      limit_q <= 9'h000;
      sent_q <= 9'h000;
      busy_q <= 1'b0;
      cmd_done_q <= 1'b0;
      cmd_reject_q <= 1'b0;
      ext_page_q <= 8'h00;
      ext_idx_q <= 7'h00;
      ext_pc_q <= 2'h0;
    end
    else
    begin
      cmd_done_q <= 1'b0;
      cmd_reject_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (cdb_valid)
          begin
            if (cdb_b0 != `MSR_OPCODE || sel == 3'd7)
              cmd_reject_q <= 1'b1;
            else if (cdb_b4 == 8'h00)
              cmd_done_q <= 1'b1;
            else
            begin
              pc_q <= cdb_b2[7:6];
              ext_pc_q <= cdb_b2[7:6];
              slot_q <= (sel == 3'd6) ? 3'd0 : sel;
              slot_last_q <= (sel == 3'd6) ? 3'd5 : sel;
              total_q <= reply_len;
              // truncate at the smaller of reply and allocation
              limit_q <= (reply_len < {1'b0, cdb_b4}) ? reply_len : {1'b0, cdb_b4};
              sent_q <= 9'h000;
              hdr_q <= 1'b1;
              pos_q <= 7'h00;
              busy_q <= 1'b1;
              st_q <= ST_FETCH;
            end
          end
        end
        ST_FETCH:
        begin
          ext_page_q <= slot_code(slot_q);
          ext_idx_q <= pos_q;
          st_q <= ST_PUSH;
        end
        ST_PUSH:
        begin
          if (push)
          begin
            sent_q <= sent_d;
            if (sent_d == limit_q || (!hdr_q && slot_q == slot_last_q
                && {2'b00, pos_q} == slot_len(slot_q) - 9'h001))
              st_q <= ST_DRAIN;
            else
            begin
              st_q <= ST_FETCH;
              if (hdr_q && pos_q == 7'h03)
              begin
                hdr_q <= 1'b0; // pages follow from byte 4
                pos_q <= 7'h00;
              end
              else if (!hdr_q && {2'b00, pos_q} == slot_len(slot_q) - 9'h001)
              begin
                slot_q <= slot_q + 3'd1;
                pos_q <= 7'h00;
              end
              else
                pos_q <= pos_q + 7'h01;
            end
          end
        end
        ST_DRAIN:
        begin
          // done only once the last byte has left the head stage
          if (fifo_idle)
          begin
            cmd_done_q <= 1'b1;
            busy_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // msr_responder

// ==== verification/msr_responder_asserts.sv ====
`timescale 1ns/100ps
// ----
// reply stream checker
// ----
module msr_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cdb_valid,
  input wire logic [7:0] cdb_b0,
  input wire logic [7:0] cdb_b2,
  input wire logic [7:0] cdb_b4,
  input wire logic [1:0] ext_pc_q,
  input wire logic busy_q,
  input wire logic cmd_done_q,
  input wire logic cmd_reject_q,
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready
);
  logic [5:0] sel_q;
  logic [1:0] pc_q;
  logic [7:0] alloc_q;
  logic [8:0] cnt_q;
  logic go, ok, mv, e;
  // byte positions only mean something relative to the command taken
  assign go = cdb_valid && !busy_q;
  assign ok = cdb_b0 == 8'h1A && cdb_b2[5:0] inside {6'h1D, 6'h1E, 6'h1F, 6'h22, 6'h3D, 6'h3E, 6'h3F};
  assign mv = out_valid && out_ready;
  assign e = sel_q == 6'h1D || sel_q == 6'h3F;
  // latch command fields, count bytes handed over
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_q <= 6'h00;
      pc_q <= 2'h0;
      alloc_q <= 8'h00;
      cnt_q <= 9'h000;
    end
    else if (go)
    begin
      sel_q <= cdb_b2[5:0];
      pc_q <= cdb_b2[7:6];
      alloc_q <= cdb_b4;
      cnt_q <= 9'h000;
    end
    else if (mv)
      cnt_q <= cnt_q + 9'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_reject; go && cdb_b0 != 8'h1A |=> cmd_reject_q && !busy_q; endproperty
  a_reject: assert property (p_reject) else $error("foreign opcode not refused");
  property p_accept; go && ok && cdb_b4 != 8'h00 |=> busy_q && !cmd_reject_q; endproperty
  a_accept: assert property (p_accept) else $error("valid command not started");
  property p_zero; go && ok && cdb_b4 == 8'h00 |=> cmd_done_q && !busy_q ##1 !out_valid; endproperty
  a_zero: assert property (p_zero) else $error("zero length not closed at once");
  property p_limit; mv |-> cnt_q < {1'b0, alloc_q}; endproperty
  a_limit: assert property (p_limit) else $error("byte beyond allocation");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_len; mv && cnt_q == 9'h000 && sel_q == 6'h1D |-> out_data == 8'h15; endproperty
  a_len: assert property (p_len) else $error("header length wrong");
  property p_hdr; mv && cnt_q > 9'h000 && cnt_q < 9'h004 |-> out_data == 8'h00; endproperty
  a_hdr: assert property (p_hdr) else $error("header byte not zero");
  property p_code; mv && e && cnt_q == 9'h004 |-> out_data == 8'h9D; endproperty
  a_code: assert property (p_code) else $error("page code byte wrong");
  property p_plen; mv && e && cnt_q == 9'h005 |-> out_data == 8'h12; endproperty
  a_plen: assert property (p_plen) else $error("page length byte wrong");
  property p_xcnt; mv && e && pc_q != 2'h1 && cnt_q == 9'h009 |-> out_data == 8'h01; endproperty
  a_xcnt: assert property (p_xcnt) else $error("transport count wrong");
  property p_pc; busy_q |-> ext_pc_q == pc_q; endproperty
  a_pc: assert property (p_pc) else $error("page control not kept");
  c_reject: cover property (cmd_reject_q);
  c_stall: cover property (out_valid && !out_ready);
  c_done: cover property (busy_q ##1 cmd_done_q);
endmodule // msr_chk

bind msr_responder msr_chk u_chk (.clk(clk), .arst_n(arst_n), .cdb_valid(cdb_valid), .cdb_b0(cdb_b0),
  .cdb_b2(cdb_b2), .cdb_b4(cdb_b4), .ext_pc_q(ext_pc_q), .busy_q(busy_q), .cmd_done_q(cmd_done_q),
  .cmd_reject_q(cmd_reject_q), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

// ==== verification/msr_host.sv ====
`timescale 1ns/100ps
// ----
// initiator sink for the reply stream
// ----
module msr_host (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  logic [7:0] rx [0:255];
  int n;
  logic [1:0] ph;
  // slow mode takes one byte in four so the reply fifo backs up
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      n <= 0;
      ph <= 2'h0;
      out_ready <= 1'b0;
    end
    else
    begin
      ph <= ph + 2'h1;
      out_ready <= !slow || ph == 2'h3;
      if (start)
        n <= 0;
      else if (out_valid && out_ready)
      begin
        rx[n[7:0]] <= out_data;
        n <= n + 1;
      end
    end
  end
endmodule // msr_host

// ==== verification/msr_responder_tb.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, s); end end
module msr_responder_tb;
  logic clk = 0, arst_n = 0, cdb_valid = 0, bus_reset = 0, pg_wr_en = 0, pg_wr_bank = 0, slow = 0;
  logic [7:0] cdb_b0 = 8'h1A, cdb_b2 = 8'h00, cdb_b4 = 8'h00, pg_wr_data = 8'h00;
  logic [7:0] ext_byte, ext_page_q, out_data;
  logic [3:0] pg_wr_addr = 4'h0;
  logic [6:0] ext_idx_q;
  logic [1:0] ext_pc_q;
  logic busy_q, cmd_done_q, cmd_reject_q, out_valid, out_ready, cur_ok = 0, sav_ok = 0;
  logic [7:0] mem [0:1][0:15];
  int err_count = 0, checks_done = 0, t;
  // rows: selector byte, allocation, expected byte count
  logic [23:0] rows [0:12] = '{24'h1DFF18, 24'h5DFF18, 24'h9DFF18, 24'hDDFF18, 24'h1EFF08, 24'h1FFF18,
    24'h22FF58, 24'h3DFF14, 24'h3EFF26, 24'hBFFFB6, 24'h9D0202, 24'h3F1717, 24'h1D0000};
  always #50 clk = ~clk;
  // other pages answered with a pattern tied to page and position
  assign ext_byte = ext_page_q + {1'b0, ext_idx_q};
  msr_responder u_dut (.clk(clk), .arst_n(arst_n), .cdb_valid(cdb_valid), .cdb_b0(cdb_b0), .cdb_b2(cdb_b2),
    .cdb_b4(cdb_b4), .bus_reset(bus_reset), .pg_wr_en(pg_wr_en), .pg_wr_bank(pg_wr_bank),
    .pg_wr_addr(pg_wr_addr), .pg_wr_data(pg_wr_data), .ext_byte(ext_byte), .ext_page_q(ext_page_q),
    .ext_idx_q(ext_idx_q), .ext_pc_q(ext_pc_q), .busy_q(busy_q), .cmd_done_q(cmd_done_q),
    .cmd_reject_q(cmd_reject_q), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
  msr_host u_host (.clk(clk), .arst_n(arst_n), .start(cdb_valid && !busy_q), .slow(slow),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  // ----
  // reference reply
  // ----
  function automatic int plen(input logic [5:0] p);
    case (p)
      6'h1E: return 4;
      6'h22: return 84;
      6'h3D: return 16;
      6'h3E: return 34;
      default: return 20;
    endcase
  endfunction
  function automatic logic [7:0] eaa(input logic [1:0] pc, input int j);
    logic [7:0] df [0:15] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h10, 8'h02, 8'h00, 8'h00,
      8'h01, 8'h03, 8'h00, 8'h00, 8'h02};
    int b;
    b = j - 2;
    if (j == 0) return 8'h9D;
    if (j == 1) return 8'h12;
    if (j > 17) return 8'h00;
    if (pc == 2'h1) return b[1] ? 8'h00 : 8'hFF;
    if (b == 2 || b == 3 || pc == 2'h2 || !sav_ok && !(pc == 2'h0 && cur_ok)) return df[b];
    return mem[pc == 2'h0 && cur_ok ? 0 : 1][b];
  endfunction
  function automatic logic [7:0] exp_b(input logic [7:0] b2, input int k);
    logic [7:0] pl [0:5] = '{8'h1D, 8'h1E, 8'h1F, 8'h22, 8'h3D, 8'h3E};
    int j;
    j = k - 4;
    if (k == 0) return b2[5:0] == 6'h3F ? 8'hB3 : 8'(plen(b2[5:0]) + 1);
    if (k < 4) return 8'h00;
    foreach (pl[i])
      if (b2[5:0] == 6'h3F || b2[5:0] == pl[i][5:0])
      begin
        if (j < plen(pl[i][5:0])) return pl[i] == 8'h1D ? eaa(b2[7:6], j) : pl[i] + 8'(j);
        j -= plen(pl[i][5:0]);
      end
    return 8'h00;
  endfunction
  // ----
  // drivers
  // ----
  task automatic conclude;
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b0, input logic [7:0] b2, input logic [7:0] b4);
    @(negedge clk);
    cdb_b0 = b0;
    cdb_b2 = b2;
    cdb_b4 = b4;
    cdb_valid = 1;
    @(negedge clk);
    cdb_valid = 0;
  endtask
  // bounded wait for the end of a command
  task automatic fin;
    t = 0;
    while (cmd_done_q !== 1'b1 && cmd_reject_q !== 1'b1 && t < 3000)
    begin
      @(negedge clk);
      t++;
    end
    if (t == 3000)
    begin
      err_count++;
      conclude;
    end
  endtask
  task automatic chk(input logic [23:0] r);
    `CHK("count", r[7:0], u_host.n[7:0])
    for (int k = 0; k < r[7:0]; k++) `CHK("byte", exp_b(r[23:16], k), u_host.rx[k])
  endtask
  task automatic run(input logic [23:0] r);
    cmd(8'h1A, r[23:16], r[15:8]);
    fin;
    chk(r);
  endtask
  // body bytes of one bank; write strobe held high across the burst
  task automatic wr(input logic bank, input logic [7:0] base);
    for (int k = 0; k < 16; k++)
    begin
      @(negedge clk);
      pg_wr_en = 1;
      pg_wr_bank = bank;
      pg_wr_addr = 4'(k);
      pg_wr_data = base + 8'(k);
      mem[bank][k] = base + 8'(k);
    end
    @(negedge clk);
    pg_wr_en = 0;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    arst_n = 1;
    foreach (rows[i]) run(rows[i]);
    // foreign opcode, then unsupported selector
    cmd(8'h12, 8'h1D, 8'hFF);
    fin;
    `CHK("reject", 1'b1, cmd_reject_q)
    cmd(8'h1A, 8'h05, 8'hFF);
    fin;
    `CHK("reject", 1'b1, cmd_reject_q)
    // second command while busy is dropped
    cmd(8'h1A, 8'h9D, 8'hFF);
    cmd(8'h1A, 8'hBF, 8'hFF);
    fin;
    chk(24'h9DFF18);
    // saved, then current, then bus reset falls back to saved
    wr(1'b1, 8'hA0);
    sav_ok = 1;
    run(24'hDDFF18);
    run(24'h1DFF18);
    wr(1'b0, 8'h50);
    cur_ok = 1;
    run(24'h1DFF18);
    run(24'h9DFF18);
    run(24'h5DFF18);
    run(24'hDDFF18);
    @(negedge clk);
    bus_reset = 1;
    @(negedge clk);
    bus_reset = 0;
    cur_ok = 0;
    run(24'h1DFF18);
    // page write in the bus reset cycle keeps current values valid
    @(negedge clk);
    bus_reset = 1;
    pg_wr_en = 1;
    pg_wr_bank = 0;
    pg_wr_addr = 4'h6;
    pg_wr_data = 8'h77;
    mem[0][6] = 8'h77;
    @(negedge clk);
    bus_reset = 0;
    pg_wr_en = 0;
    cur_ok = 1;
    run(24'h1DFF18);
    // slow host backs the fifo up to full
    slow = 1;
    run(24'hBFFFB6);
    slow = 0;
    // reset in mid reply clears outputs and the page validity flags
    cmd(8'h1A, 8'h3F, 8'hFF);
    repeat (20) @(negedge clk);
    arst_n = 0;
    #1;
    `CHK("busy", 1'b0, busy_q)
    `CHK("valid", 1'b0, out_valid)
    cur_ok = 0;
    sav_ok = 0;
    @(negedge clk);
    arst_n = 1;
    run(24'h1DFF18);
    conclude;
  end
endmodule // msr_responder_tb
